// [verilog/rtcpa_regs.vh]
`ifndef RTCPA_REGS_VH
`define RTCPA_REGS_VH

// register byte offsets
`define RTCPA_OFS_STROBE4_CTRL 8'h00
`define RTCPA_OFS_STROBE3_CTRL 8'h04
`define RTCPA_OFS_CAPTURE_CFG 8'h08
`define RTCPA_OFS_IRQ_STATUS3 8'h0C
`define RTCPA_OFS_SYNC_STATUS 8'h10
`define RTCPA_OFS_PEND_STATUS 8'h14
`define RTCPA_OFS_OUT_MASK 8'h18
`define RTCPA_OFS_CAPTURE3 8'h1C
`define RTCPA_OFS_CAPTURE4 8'h20
`define RTCPA_OFS_UNREAD_STATUS 8'h24

// sync status field positions
`define RTCPA_SYNC_STROBE4 3
`define RTCPA_SYNC_STROBE3 2
`define RTCPA_SYNC_CAPCFG 1
`define RTCPA_SYNC_IRQCLR 0

// pending status field positions
`define RTCPA_PEND_OUTMASK 15
`define RTCPA_PEND_CAP4 14
`define RTCPA_PEND_CAP3 13

// unread status field positions
`define RTCPA_UNREAD_CAP3 0
`define RTCPA_UNREAD_CAP4 1

// reset values
`define RTCPA_RST_DATA 16'h0000
`define RTCPA_RST_PEND_STATUS 16'h0000
`define RTCPA_RST_SYNCED 1'b1
`define RTCPA_READ_ZERO 32'h0000_0000

`endif

// [verilog/rtcpa_sync.v]
`timescale 1ns/10ps
// two-flop synchroniser for the 32 kHz clock pin plus rising-edge tick
module rtcpa_sync (
    input wire clk_sys,
    input wire resetn,
    input wire lf_clk_pin,
    output wire lf_tick
);
    reg meta;
    reg stable;
    reg stable_d;

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            meta <= 1'b0;
            stable <= 1'b0;
            stable_d <= 1'b0;
        end else begin
            meta <= lf_clk_pin;
            stable <= meta;
            stable_d <= stable;
        end
    end

    assign lf_tick = stable & ~stable_d;
endmodule // rtcpa_sync

// [verilog/rtcpa_post_chan.v]
`timescale 1ns/10ps
`include "rtcpa_regs.vh"
// one posted-access slot: holds a queued access until the next 32 kHz tick
module rtcpa_post_chan (
    input wire clk_sys,
    input wire resetn,
    input wire post,
    input wire [15:0] post_data,
    input wire lf_tick,
    output reg pending,
    output reg synced,
    output reg [15:0] held_data,
    output wire execute
);
    assign execute = pending & lf_tick;

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pending <= 1'b0;
            synced <= `RTCPA_RST_SYNCED;
            held_data <= `RTCPA_RST_DATA;
        end else if (post && !pending) begin
            // a queued access refuses any newer one
            pending <= 1'b1;
            synced <= 1'b0;
            held_data <= post_data;
        end else if (execute) begin
            pending <= 1'b0;
            synced <= 1'b1;
        end
    end
endmodule // rtcpa_post_chan

// [verilog/rtcpa_top.v]
`timescale 1ns/10ps
`include "rtcpa_regs.vh"
// Operation
// - sync bit 3 is 1 once strobe 4 control write is visible.
// - sync bit 2 is 1 once strobe 3 control write is visible.
// - sync bit 1 is 1 once capture config write is visible.
// - sync bit 0 is 1 once interrupt-clear write is visible.
// - pending register shows queued always-on capture and output accesses.
// - pending register only in second instance; first reads reset value.
// - pending bit 15 set while mask write queued; new writes refused.
// - pending bit 14 set while capture 4 read awaits unread clear.
// - pending bit 13 set while capture 3 read awaits unread clear.
module rtcpa_top #(
    parameter SECOND_INSTANCE = 1
) (
    input wire clk_sys,
    input wire resetn,
    input wire [7:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    input wire [3:0] byteenable,
    output reg [31:0] readdata,
    output wire waitrequest,
    input wire lf_clk_pin,
    input wire [15:0] irq_event,
    input wire cap3_event,
    input wire cap4_event,
    input wire [15:0] cap3_value,
    input wire [15:0] cap4_value,
    output reg [15:0] strobe4_ctrl,
    output reg [15:0] strobe3_ctrl,
    output reg [15:0] capture_cfg,
    output reg [15:0] out_mask,
    output reg [15:0] irq_status3
);
    wire lf_tick;
    reg ack;
    wire req;
    wire take;
    reg cap3_unread;
    reg cap4_unread;
    reg [15:0] cap3_data;
    reg [15:0] cap4_data;

    wire om_pend;
    wire r3_pend;
    wire r4_pend;
    wire s4_sync;
    wire s3_sync;
    wire cc_sync;
    wire ic_sync;
    wire [15:0] s4_hold;
    wire [15:0] s3_hold;
    wire [15:0] cc_hold;
    wire [15:0] ic_hold;
    wire [15:0] om_hold;
    wire s4_exec;
    wire s3_exec;
    wire cc_exec;
    wire ic_exec;
    wire om_exec;
    wire r3_exec;
    wire r4_exec;
    wire [15:0] sync_status;
    wire [15:0] pend_status;
    reg [31:0] next_readdata;

    // merges enabled byte lanes of the low half-word
    function [15:0] merge16;
        input [15:0] old_val;
        input [31:0] new_val;
        input [3:0] be;
        begin
            merge16[7:0] = be[0] ? new_val[7:0] : old_val[7:0];
            merge16[15:8] = be[1] ? new_val[15:8] : old_val[15:8];
        end
    endfunction

    // true when the bus address selects the given register
    function addr_hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            addr_hit = (addr == ofs);
        end
    endfunction

    // one request slot: first cycle waits, second completes
    assign req = read | write;
    assign waitrequest = req & ~ack;
    assign take = req & ack;

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ack <= 1'b0;
        end else begin
            ack <= req & ~ack;
        end
    end

    rtcpa_sync u_sync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .lf_clk_pin(lf_clk_pin),
        .lf_tick(lf_tick)
    );

    wire wr_s4 = take & write & addr_hit(address, `RTCPA_OFS_STROBE4_CTRL);
    wire wr_s3 = take & write & addr_hit(address, `RTCPA_OFS_STROBE3_CTRL);
    wire wr_cc = take & write & addr_hit(address, `RTCPA_OFS_CAPTURE_CFG);
    wire wr_ic = take & write & addr_hit(address, `RTCPA_OFS_IRQ_STATUS3);
    wire wr_om = take & write & addr_hit(address, `RTCPA_OFS_OUT_MASK);
    wire rd_c3 = take & read & addr_hit(address, `RTCPA_OFS_CAPTURE3);
    wire rd_c4 = take & read & addr_hit(address, `RTCPA_OFS_CAPTURE4);

    rtcpa_post_chan u_s4 (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .post(wr_s4),
        .post_data(merge16(strobe4_ctrl, writedata, byteenable)),
        .lf_tick(lf_tick),
        .pending(),
        .synced(s4_sync),
        .held_data(s4_hold),
        .execute(s4_exec)
    );

    rtcpa_post_chan u_s3 (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .post(wr_s3),
        .post_data(merge16(strobe3_ctrl, writedata, byteenable)),
        .lf_tick(lf_tick),
        .pending(),
        .synced(s3_sync),
        .held_data(s3_hold),
        .execute(s3_exec)
    );

    rtcpa_post_chan u_cc (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .post(wr_cc),
        .post_data(merge16(capture_cfg, writedata, byteenable)),
        .lf_tick(lf_tick),
        .pending(),
        .synced(cc_sync),
        .held_data(cc_hold),
        .execute(cc_exec)
    );

    // interrupt clear: ones in disabled lanes clear nothing
    rtcpa_post_chan u_ic (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .post(wr_ic),
        .post_data(merge16(`RTCPA_RST_DATA, writedata, byteenable)),
        .lf_tick(lf_tick),
        .pending(),
        .synced(ic_sync),
        .held_data(ic_hold),
        .execute(ic_exec)
    );

    rtcpa_post_chan u_om (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .post(wr_om),
        .post_data(merge16(out_mask, writedata, byteenable)),
        .lf_tick(lf_tick),
        .pending(om_pend),
        .synced(),
        .held_data(om_hold),
        .execute(om_exec)
    );

    rtcpa_post_chan u_r3 (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .post(rd_c3),
        .post_data(`RTCPA_RST_DATA),
        .lf_tick(lf_tick),
        .pending(r3_pend),
        .synced(),
        .held_data(),
        .execute(r3_exec)
    );

    rtcpa_post_chan u_r4 (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .post(rd_c4),
        .post_data(`RTCPA_RST_DATA),
        .lf_tick(lf_tick),
        .pending(r4_pend),
        .synced(),
        .held_data(),
        .execute(r4_exec)
    );

    // always-on copies take queued values on the tick
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            strobe4_ctrl <= `RTCPA_RST_DATA;
            strobe3_ctrl <= `RTCPA_RST_DATA;
            capture_cfg <= `RTCPA_RST_DATA;
            out_mask <= `RTCPA_RST_DATA;
            irq_status3 <= `RTCPA_RST_DATA;
        end else begin
            if (s4_exec) begin
                strobe4_ctrl <= s4_hold;
            end
            if (s3_exec) begin
                strobe3_ctrl <= s3_hold;
            end
            if (cc_exec) begin
                capture_cfg <= cc_hold;
            end
            if (om_exec) begin
                out_mask <= om_hold;
            end
            // new events win over a clear in the same cycle
            if (ic_exec) begin
                irq_status3 <= (irq_status3 & ~ic_hold) | irq_event;
            end else begin
                irq_status3 <= irq_status3 | irq_event;
            end
        end
    end

    // capture channels: event latches value and marks unread
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cap3_unread <= 1'b0;
            cap4_unread <= 1'b0;
            cap3_data <= `RTCPA_RST_DATA;
            cap4_data <= `RTCPA_RST_DATA;
        end else begin
            if (cap3_event) begin
                cap3_data <= cap3_value;
            end
            if (cap4_event) begin
                cap4_data <= cap4_value;
            end
            if (cap3_event) begin
                cap3_unread <= 1'b1;
            end else if (r3_exec) begin
                cap3_unread <= 1'b0;
            end
            if (cap4_event) begin
                cap4_unread <= 1'b1;
            end else if (r4_exec) begin
                cap4_unread <= 1'b0;
            end
        end
    end

    assign sync_status[`RTCPA_SYNC_STROBE4] = s4_sync;
    assign sync_status[`RTCPA_SYNC_STROBE3] = s3_sync;
    assign sync_status[`RTCPA_SYNC_CAPCFG] = cc_sync;
    assign sync_status[`RTCPA_SYNC_IRQCLR] = ic_sync;
    assign sync_status[15:4] = 12'h000;

    assign pend_status[`RTCPA_PEND_OUTMASK] = om_pend;
    assign pend_status[`RTCPA_PEND_CAP4] = r4_pend;
    assign pend_status[`RTCPA_PEND_CAP3] = r3_pend;
    assign pend_status[12:0] = 13'h0;

    always @* begin
        next_readdata = `RTCPA_READ_ZERO;
        if (address == `RTCPA_OFS_STROBE4_CTRL) begin
            next_readdata[15:0] = strobe4_ctrl;
        end else if (address == `RTCPA_OFS_STROBE3_CTRL) begin
            next_readdata[15:0] = strobe3_ctrl;
        end else if (address == `RTCPA_OFS_CAPTURE_CFG) begin
            next_readdata[15:0] = capture_cfg;
        end else if (address == `RTCPA_OFS_IRQ_STATUS3) begin
            next_readdata[15:0] = irq_status3;
        end else if (address == `RTCPA_OFS_SYNC_STATUS) begin
            next_readdata[15:0] = sync_status;
        end else if (address == `RTCPA_OFS_PEND_STATUS) begin
            if (SECOND_INSTANCE != 0) begin
                next_readdata[15:0] = pend_status;
            end else begin
                next_readdata[15:0] = `RTCPA_RST_PEND_STATUS;
            end
        end else if (address == `RTCPA_OFS_OUT_MASK) begin
            next_readdata[15:0] = out_mask;
        end else if (address == `RTCPA_OFS_CAPTURE3) begin
            next_readdata[15:0] = cap3_data;
        end else if (address == `RTCPA_OFS_CAPTURE4) begin
            next_readdata[15:0] = cap4_data;
        end else if (address == `RTCPA_OFS_UNREAD_STATUS) begin
            next_readdata[`RTCPA_UNREAD_CAP3] = cap3_unread;
            next_readdata[`RTCPA_UNREAD_CAP4] = cap4_unread;
        end
    end

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            readdata <= `RTCPA_READ_ZERO;
        end else if (read & ~ack) begin
            readdata <= next_readdata;
        end
    end
endmodule // rtcpa_top

// [verification/rtcpa_top_assertions.sv]
`timescale 1ns/10ps
module rtcpa_checker (
    input wire clk_sys,
    input wire resetn,
    input wire read,
    input wire write,
    input wire [31:0] readdata,
    input wire waitrequest,
    input wire lf_clk_pin,
    input wire [15:0] irq_event,
    input wire [15:0] strobe4_ctrl,
    input wire [15:0] capture_cfg,
    input wire [15:0] out_mask,
    input wire [15:0] irq_status3
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    // posted values only move a few cycles after a slow clock rise
    sequence after_rise;
        $past(lf_clk_pin, 2) && !$past(lf_clk_pin, 7);
    endsequence
    a_wait_one: assert property ((read | write) && waitrequest
        |=> !waitrequest) else $error("bus answer late");
    a_strobe4_post: assert property ($changed(strobe4_ctrl)
        |-> after_rise) else $error("strobe4 moved off tick");
    a_capcfg_post: assert property ($changed(capture_cfg)
        |-> after_rise) else $error("capture cfg moved off tick");
    a_mask_post: assert property ($changed(out_mask)
        |-> after_rise) else $error("out mask moved off tick");
    a_irq_clear: assert property ((($past(irq_status3) & ~irq_status3)
        != 16'h0000) |-> after_rise) else $error("irq cleared off tick");
    a_irq_set: assert property (irq_event != 16'h0000
        |=> (irq_status3 & $past(irq_event)) == $past(irq_event))
        else $error("irq event lost");
    a_upper_zero: assert property (read && !waitrequest
        |-> readdata[31:16] == 16'h0000) else $error("upper half set");
    a_rdata_hold: assert property ($changed(readdata)
        |-> $past(read)) else $error("readdata moved without read");
    c_write_done: cover property (write && !waitrequest);
    c_read_done: cover property (read && !waitrequest);
    c_mask_exec: cover property ($changed(out_mask));
endmodule // rtcpa_checker

// [verification/rtcpa_cpu_model.sv]
`timescale 1ns/10ps
module rtcpa_cpu_model (
    input wire clk_sys,
    input wire waitrequest,
    input wire [31:0] readdata,
    output logic [7:0] address,
    output logic read,
    output logic write,
    output logic [31:0] writedata,
    output logic [3:0] byteenable
);
    // byte lanes the bench may narrow for one write
    logic [3:0] lanes = 4'hF;
    initial begin
        address = 8'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0000_0000;
        byteenable = 4'hF;
    end
    // request held until waitrequest is sampled low
    task automatic access(input logic wr, input logic [7:0] a,
            input logic [15:0] d, output logic [31:0] q);
        @(posedge clk_sys);
        address <= a;
        read <= !wr;
        write <= wr;
        writedata <= {16'h0000, d};
        byteenable <= lanes;
        do @(posedge clk_sys); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
endmodule // rtcpa_cpu_model

// [verification/rtcpa_top_bench.sv]
`timescale 1ns/10ps
module rtcpa_top_bench;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic lf_clk_pin = 1'b0;
    logic [15:0] irq_event = 16'h0000;
    logic cap3_event = 1'b0;
    logic cap4_event = 1'b0;
    logic [15:0] cap3_value = 16'h0000;
    logic [15:0] cap4_value = 16'h0000;
    logic [7:0] address;
    logic read, write, waitrequest;
    logic [31:0] writedata, readdata, q;
    logic [3:0] byteenable;
    logic [15:0] strobe4_ctrl, strobe3_ctrl, capture_cfg, out_mask;
    logic [15:0] irq_status3;
    logic [15:0] d [0:3];
    integer fail_count = 0;
    integer n_compared = 0;
    integer seed = 43781;
    integer i;
    integer m_reg [0:9];
    integer m_next [0:9];
    integer post_q [$];
    logic [31:0] readdata_first;
    always #2.5 clk_sys = ~clk_sys;
    rtcpa_top i_rtcpa_top (.clk_sys(clk_sys), .resetn(resetn),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .lf_clk_pin(lf_clk_pin), .irq_event(irq_event),
        .cap3_event(cap3_event), .cap4_event(cap4_event),
        .cap3_value(cap3_value), .cap4_value(cap4_value),
        .strobe4_ctrl(strobe4_ctrl), .strobe3_ctrl(strobe3_ctrl),
        .capture_cfg(capture_cfg), .out_mask(out_mask),
        .irq_status3(irq_status3));
    rtcpa_cpu_model i_rtcpa_cpu_model (.clk_sys(clk_sys),
        .waitrequest(waitrequest), .readdata(readdata),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable));
    rtcpa_top #(.SECOND_INSTANCE(0)) i_rtcpa_top_first (.clk_sys(clk_sys),
        .resetn(resetn), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata_first), .waitrequest(),
        .lf_clk_pin(lf_clk_pin), .irq_event(irq_event),
        .cap3_event(cap3_event), .cap4_event(cap4_event),
        .cap3_value(cap3_value), .cap4_value(cap4_value),
        .strobe4_ctrl(), .strobe3_ctrl(), .capture_cfg(), .out_mask(),
        .irq_status3());
    task chk(input string name, input logic [31:0] exp,
            input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s exp %h got %h", name, exp, got);
        end
    endtask
    task chk_out(input string name, input integer exp,
            input logic [15:0] got);
        n_compared++;
        if (got !== exp[15:0]) begin
            fail_count++;
            $display("unexpected %s exp %h got %h", name, exp[15:0], got);
        end
    endtask
    task bus(input logic wr, input logic [7:0] a, input logic [15:0] v);
        integer k;
        integer lanes;
        k = a >> 2;
        lanes = {{8{i_rtcpa_cpu_model.lanes[1]}},
            {8{i_rtcpa_cpu_model.lanes[0]}}};
        i_rtcpa_cpu_model.access(wr, a, v, q);
        // a slot still queued refuses the newer write
        if (wr && (k <= 3 || k == 6) && !(k inside {post_q})) begin
            post_q.push_back(k);
            if (k == 3)
                m_next[k] = v & lanes;
            else
                m_next[k] = (m_reg[k] & ~lanes) | (v & lanes);
        end
    endtask
    function automatic integer exp_sync();
        exp_sync = 15;
        foreach (post_q[n])
            if (post_q[n] <= 3)
                exp_sync = exp_sync & ~(8 >> post_q[n]);
    endfunction
    task lf_tick;
        @(posedge clk_sys);
        lf_clk_pin <= 1'b1;
        repeat (10) @(posedge clk_sys);
        lf_clk_pin <= 1'b0;
        repeat (10) @(posedge clk_sys);
        foreach (post_q[n]) begin
            if (post_q[n] == 3)
                m_reg[3] = m_reg[3] & ~m_next[3];
            else
                m_reg[post_q[n]] = m_next[post_q[n]];
        end
        post_q.delete();
    endtask
    task summarize;
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        foreach (m_reg[n]) m_reg[n] = 0;
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        bus(0, 8'h10, 0);
        chk("sync", exp_sync(), q);
        // software checks pending before posting
        bus(0, 8'h14, 0);
        chk("pend", 32'h0000, q);
        $display("reset test done");
        for (i = 0; i < 4; i++) d[i] = 16'($random(seed));
        bus(1, 8'h00, d[0]);
        bus(1, 8'h04, d[1]);
        bus(1, 8'h08, d[2]);
        bus(1, 8'h18, d[3]);
        bus(0, 8'h10, 0);
        chk("sync", exp_sync(), q);
        bus(0, 8'h14, 0);
        chk("pend", 32'h8000, q);
        chk("pend first", 32'h0000, readdata_first);
        bus(1, 8'h18, ~d[3]);
        lf_tick;
        chk_out("strobe4", m_reg[0], strobe4_ctrl);
        chk_out("strobe3", m_reg[1], strobe3_ctrl);
        chk_out("capcfg", m_reg[2], capture_cfg);
        chk_out("mask", m_reg[6], out_mask);
        bus(0, 8'h10, 0);
        chk("sync", exp_sync(), q);
        bus(0, 8'h14, 0);
        chk("pend", 32'h0000, q);
        // only the low lane of strobe 3 takes the new value
        i_rtcpa_cpu_model.lanes = 4'h1;
        bus(1, 8'h04, ~d[1]);
        i_rtcpa_cpu_model.lanes = 4'hF;
        lf_tick;
        chk_out("strobe3 lane", m_reg[1], strobe3_ctrl);
        $display("posted write test done");
        d[0] = 16'($random(seed));
        d[1] = 16'($random(seed));
        @(posedge clk_sys);
        irq_event <= d[0];
        m_reg[3] = m_reg[3] | d[0];
        @(posedge clk_sys);
        irq_event <= 16'h0000;
        @(posedge clk_sys);
        chk_out("irq", m_reg[3], irq_status3);
        bus(1, 8'h0C, d[1]);
        bus(0, 8'h10, 0);
        chk("sync", exp_sync(), q);
        lf_tick;
        chk_out("irq", m_reg[3], irq_status3);
        bus(0, 8'h10, 0);
        chk("sync", exp_sync(), q);
        $display("irq clear test done");
        for (i = 0; i < 2; i++) begin
            d[0] = 16'($random(seed));
            @(posedge clk_sys);
            cap3_value <= d[0];
            cap4_value <= d[0];
            cap3_event <= (i == 0);
            cap4_event <= (i == 1);
            @(posedge clk_sys);
            cap3_event <= 1'b0;
            cap4_event <= 1'b0;
            bus(0, (i == 0) ? 8'h1C : 8'h20, 0);
            chk("capture", {16'h0000, d[0]}, q);
            bus(0, 8'h14, 0);
            chk("pend", (i == 0) ? 32'h2000 : 32'h4000, q);
            bus(0, 8'h24, 0);
            chk("unread", 32'(i + 1), q);
            lf_tick;
            bus(0, 8'h24, 0);
            chk("unread", 32'h0000, q);
            bus(0, 8'h14, 0);
            chk("pend", 32'h0000, q);
        end
        $display("capture read test done");
        bus(0, 8'h30, 0);
        chk("unmapped", 32'h0000, q);
        $display("unmapped test done");
        summarize;
    end
    initial begin
        #100000;
        fail_count++;
        summarize;
    end
endmodule // rtcpa_top_bench
bind rtcpa_top rtcpa_checker i_rtcpa_checker (.clk_sys(clk_sys),
    .resetn(resetn), .read(read), .write(write), .readdata(readdata),
    .waitrequest(waitrequest), .lf_clk_pin(lf_clk_pin),
    .irq_event(irq_event), .strobe4_ctrl(strobe4_ctrl),
    .capture_cfg(capture_cfg), .out_mask(out_mask),
    .irq_status3(irq_status3));
